// ==== logic/charger_setpoint_registers.sv ====
`timescale 1ns/1ns
`include "charger_cfg.svh"

module charger_setpoint_registers
   import charger_pkg::*;
(
   // Clock and reset
   input  wire logic      clk,
   input  wire logic      arst_n,
   // Two-wire bus pins
   input  wire logic      scl_in,
   input  wire logic      sda_in,
   output logic           sda_out,
   output logic           sda_oe,
   // Device events
   input  wire logic      reg_reset,
   input  wire logic      watchdog_expire,
   input  wire logic      plugin_detect_done,
   // Applied setpoints and mode flag
   output setpoint_t      setpoints,
   output logic           watchdog_expired_flag
);

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic reg_defined(input logic [7:0] a);
      reg_defined = (a <= `OFS_INPUT_CURRENT);
   endfunction

   // ************************************************************
   // Declarations
   // ************************************************************
   logic        scl_q;
   logic        sda_q;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_cond;
   logic        stop_cond;

   bus_state_t  state_reg;
   bus_state_t  state_next;
   bus_state_t  after_reg;
   bus_state_t  after_next;
   logic [3:0]  cnt_reg;
   logic [3:0]  cnt_next;
   logic [7:0]  shift_reg;
   logic [7:0]  shift_next;
   logic [7:0]  tx_reg;
   logic [7:0]  tx_next;
   logic [7:0]  ptr_reg;
   logic [7:0]  ptr_next;
   logic [7:0]  ptr_inc;
   logic        oe_reg;
   logic        oe_next;
   reg_write_t  wr_reg;
   reg_write_t  wr_next;
   logic [7:0]  rd_data;

   logic [7:0]  cell_reg;
   logic [7:0]  cell_next;
   logic [7:0]  chg_reg;
   logic [7:0]  chg_next;
   logic [7:0]  vin_reg;
   logic [7:0]  vin_next;
   logic [7:0]  iin_reg;
   logic [7:0]  iin_next;
   logic        wdflag_reg;
   logic        wdflag_next;

   setpoint_t   applied_reg;
   setpoint_t   applied_next;

   // ************************************************************
   // Pin edge detection
   // ************************************************************
   // The pins are taken as synchronous, so one stage of history is enough to see edges.
   assign scl_rise   = scl_in & ~scl_q;
   assign scl_fall   = ~scl_in & scl_q;
   assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
   assign stop_cond  = scl_in & scl_q & ~sda_q & sda_in;
   assign ptr_inc    = ptr_reg + 8'h01;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   // ************************************************************
   // Read data selection
   // ************************************************************
   // Reads show the stored byte, so codes beyond the clamps read back as written.
   always_comb begin
      rd_data = 8'h00;
      unique case (ptr_reg)
         `OFS_CELL_VOLTAGE:   rd_data = cell_reg;
         `OFS_CHARGE_CURRENT: rd_data = chg_reg;
         `OFS_INPUT_VOLTAGE:  rd_data = vin_reg;
         `OFS_INPUT_CURRENT:  rd_data = iin_reg;
         default:             rd_data = 8'h00;
      endcase
   end

   // ************************************************************
   // Bus engine
   // ************************************************************
   always_comb begin
      state_next = state_reg;
      after_next = after_reg;
      cnt_next   = cnt_reg;
      shift_next = shift_reg;
      tx_next    = tx_reg;
      ptr_next   = ptr_reg;
      oe_next    = oe_reg;
      wr_next    = '0;
      if (scl_rise) begin
         shift_next = {shift_reg[6:0], sda_in};
         if (cnt_reg != 4'h8) begin
            cnt_next = cnt_reg + 4'h1;
         end
         // A master NACK after a read byte ends the transfer.
         if (state_reg == ST_MACK && sda_in) begin
            state_next = ST_IDLE;
         end
      end
      if (scl_fall) begin
         unique case (state_reg)
            ST_IDLE: begin
               oe_next = 1'b0;
            end
            ST_DEV: begin
               if (cnt_reg == 4'h8) begin
                  cnt_next = 4'h0;
                  if (shift_reg[7:1] == `I2C_TARGET_ADDR) begin
                     oe_next    = 1'b1;
                     after_next = shift_reg[0] ? ST_RD : ST_REG;
                     state_next = ST_ACK;
                  end else begin
                     state_next = ST_IDLE;
                  end
               end
            end
            ST_REG: begin
               if (cnt_reg == 4'h8) begin
                  cnt_next = 4'h0;
                  if (reg_defined(shift_reg)) begin
                     ptr_next   = shift_reg;
                     oe_next    = 1'b1;
                     after_next = ST_WR;
                     state_next = ST_ACK;
                  end else begin
                     state_next = ST_IDLE;
                  end
               end
            end
            ST_WR: begin
               if (cnt_reg == 4'h8) begin
                  cnt_next = 4'h0;
                  if (reg_defined(ptr_reg)) begin
                     wr_next.valid = 1'b1;
                     wr_next.addr  = ptr_reg;
                     wr_next.data  = shift_reg;
                     ptr_next      = ptr_inc;
                     oe_next       = 1'b1;
                     after_next    = ST_WR;
                     state_next    = ST_ACK;
                  end else begin
                     state_next = ST_IDLE;
                  end
               end
            end
            ST_ACK: begin
               cnt_next = 4'h0;
               if (after_reg == ST_RD) begin
                  oe_next = ~rd_data[7];
                  tx_next = {rd_data[6:0], 1'b1};
               end else begin
                  oe_next = 1'b0;
               end
               state_next = after_reg;
            end
            ST_RD: begin
               if (cnt_reg == 4'h8) begin
                  cnt_next   = 4'h0;
                  oe_next    = 1'b0;
                  ptr_next   = ptr_inc;
                  state_next = ST_MACK;
               end else begin
                  oe_next = ~tx_reg[7];
                  tx_next = {tx_reg[6:0], 1'b1};
               end
            end
            ST_MACK: begin
               cnt_next = 4'h0;
               if (reg_defined(ptr_reg)) begin
                  oe_next    = ~rd_data[7];
                  tx_next    = {rd_data[6:0], 1'b1};
                  state_next = ST_RD;
               end else begin
                  state_next = ST_IDLE;
               end
            end
            default: begin
               state_next = ST_IDLE;
            end
         endcase
      end
      if (start_cond) begin
         state_next = ST_DEV;
         cnt_next   = 4'h0;
         oe_next    = 1'b0;
      end else if (stop_cond) begin
         state_next = ST_IDLE;
         oe_next    = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ST_IDLE;
         after_reg <= ST_IDLE;
         cnt_reg   <= 4'h0;
         shift_reg <= 8'h00;
         tx_reg    <= 8'hFF;
         ptr_reg   <= 8'h00;
         oe_reg    <= 1'b0;
         wr_reg    <= '0;
      end else begin
         state_reg <= state_next;
         after_reg <= after_next;
         cnt_reg   <= cnt_next;
         shift_reg <= shift_next;
         tx_reg    <= tx_next;
         ptr_reg   <= ptr_next;
         oe_reg    <= oe_next;
         wr_reg    <= wr_next;
      end
   end

   // ************************************************************
   // Register bank
   // ************************************************************
   // Priority, lowest first: host write, plug-in reload, watchdog, register reset.
   // Hardware events win so a write landing in the same cycle cannot mask them.
   always_comb begin
      cell_next   = cell_reg;
      chg_next    = chg_reg;
      vin_next    = vin_reg;
      iin_next    = iin_reg;
      wdflag_next = wdflag_reg;
      if (wr_reg.valid) begin
         wdflag_next = 1'b0;
         unique case (wr_reg.addr)
            `OFS_CELL_VOLTAGE:   cell_next = wr_reg.data;
            `OFS_CHARGE_CURRENT: chg_next  = wr_reg.data;
            `OFS_INPUT_VOLTAGE:  vin_next  = wr_reg.data;
            `OFS_INPUT_CURRENT:  iin_next  = wr_reg.data;
            default:             cell_next = cell_reg;
         endcase
      end
      if (plugin_detect_done && vin_reg[`BIT_FLOOR_RELOAD]) begin
         vin_next[4:0] = `FLOOR_CODE_DEFAULT;
      end
      if (watchdog_expire) begin
         wdflag_next = 1'b1;
         cell_next   = `RST_CELL_VOLTAGE;
         chg_next    = `RST_CHARGE_CURRENT;
         vin_next    = (vin_next & `WDG_KEEP_INPUT_VOLT)
                     | (`RST_INPUT_VOLTAGE & ~`WDG_KEEP_INPUT_VOLT);
         iin_next    = (iin_next & `WDG_KEEP_INPUT_CURR)
                     | (`RST_INPUT_CURRENT & ~`WDG_KEEP_INPUT_CURR);
      end
      if (reg_reset) begin
         cell_next = `RST_CELL_VOLTAGE;
         chg_next  = `RST_CHARGE_CURRENT;
         vin_next  = `RST_INPUT_VOLTAGE;
         iin_next  = `RST_INPUT_CURRENT;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cell_reg   <= `RST_CELL_VOLTAGE;
         chg_reg    <= `RST_CHARGE_CURRENT;
         vin_reg    <= `RST_INPUT_VOLTAGE;
         iin_reg    <= `RST_INPUT_CURRENT;
         wdflag_reg <= 1'b1;
      end else begin
         cell_reg   <= cell_next;
         chg_reg    <= chg_next;
         vin_reg    <= vin_next;
         iin_reg    <= iin_next;
         wdflag_reg <= wdflag_next;
      end
   end

   // ************************************************************
   // Applied setpoints
   // ************************************************************
   always_comb begin
      applied_next                         = '0;
      applied_next.per_cell_charge_voltage = cell_reg;
      applied_next.high_impedance_enable   = chg_reg[`BIT_HIZ_ENABLE];
      applied_next.limit_pin_enable        = chg_reg[`BIT_LIMIT_PIN];
      applied_next.fast_charge_current     = chg_reg[5:0];
      if (chg_reg[5:0] > `CHARGE_CODE_MAX) begin
         applied_next.fast_charge_current = `CHARGE_CODE_MAX;
      end else if (chg_reg[5:0] < `CHARGE_CODE_MIN) begin
         applied_next.fast_charge_current = `CHARGE_CODE_MIN;
      end
      applied_next.floor_reload_on_plugin = vin_reg[`BIT_FLOOR_RELOAD];
      applied_next.battery_load_enable    = vin_reg[`BIT_BAT_LOAD];
      applied_next.out_of_audio_disable   = vin_reg[`BIT_OOA_DISABLE];
      applied_next.input_voltage_floor    = vin_reg[4:0];
      if (vin_reg[4:0] > `FLOOR_CODE_MAX) begin
         applied_next.input_voltage_floor = `FLOOR_CODE_MAX;
      end
      applied_next.input_current_limit = iin_reg;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         applied_reg           <= '0;
         sda_out               <= 1'b0;
         sda_oe                <= 1'b0;
         watchdog_expired_flag <= 1'b1;
      end else begin
         applied_reg           <= applied_next;
         sda_out               <= 1'b0;
         sda_oe                <= oe_reg;
         watchdog_expired_flag <= wdflag_reg;
      end
   end

   assign setpoints = applied_reg;

endmodule

// ==== logic/charger_cfg.svh ====
// Notes on behaviour
// - Cell voltage code: 3.40 V plus 5 mV steps.
// - Bit 7 high impedance, bit 6 limit pin.
// - Charge current bits 5:0, 50 mA steps.
// - Applied charge current code clamped to 01h..2Ch.
// - Plug-in detection reloads floor when bit 7 set.
// - Bit 6 enables battery discharge load.
// - Bit 5 disables out-of-audio; watchdog keeps it.
// - Floor bits 4:0, 3.9 V plus 100 mV.
// - Applied floor code clamped to 10h maximum.
// - Watchdog expiry restores defaults except kept fields.
// - Target address 6Bh plus read/write bit.
// - Undefined register address gets NACK, then idle.
`ifndef CHARGER_CFG_SVH
`define CHARGER_CFG_SVH

// ***************************************************************
// Bus address and register map
// ***************************************************************
`define I2C_TARGET_ADDR      7'h6B
`define OFS_CELL_VOLTAGE     8'h00
`define OFS_CHARGE_CURRENT   8'h01
`define OFS_INPUT_VOLTAGE    8'h02
`define OFS_INPUT_CURRENT    8'h03

// ***************************************************************
// Reset values and watchdog keep masks
// ***************************************************************
`define RST_CELL_VOLTAGE     8'hA0
`define RST_CHARGE_CURRENT   8'h5E
`define RST_INPUT_VOLTAGE    8'h84
`define RST_INPUT_CURRENT    8'h39
`define WDG_KEEP_INPUT_VOLT  8'h3F
`define WDG_KEEP_INPUT_CURR  8'h3F

// ***************************************************************
// Field positions and clamp limits
// ***************************************************************
`define BIT_HIZ_ENABLE       7
`define BIT_LIMIT_PIN        6
`define BIT_FLOOR_RELOAD     7
`define BIT_BAT_LOAD         6
`define BIT_OOA_DISABLE      5
`define CHARGE_CODE_MAX      6'h2C
`define CHARGE_CODE_MIN      6'h01
`define FLOOR_CODE_MAX       5'h10
`define FLOOR_CODE_DEFAULT   5'h04

`endif

// ==== logic/charger_pkg.sv ====
package charger_pkg;

   // ************************************************************
   // Bus engine states
   // ************************************************************
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DEV,
      ST_REG,
      ST_WR,
      ST_ACK,
      ST_RD,
      ST_MACK
   } bus_state_t;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic       valid;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_write_t;

   typedef struct packed {
      logic [7:0] per_cell_charge_voltage;
      logic       high_impedance_enable;
      logic       limit_pin_enable;
      logic [5:0] fast_charge_current;
      logic       floor_reload_on_plugin;
      logic       battery_load_enable;
      logic       out_of_audio_disable;
      logic [4:0] input_voltage_floor;
      logic [7:0] input_current_limit;
   } setpoint_t;

endpackage

// ==== tb/charger_setpoint_registers_asserts.sv ====
`timescale 1ns/1ns
module charger_setpoint_registers_asserts
   import charger_pkg::*;
(
   // Clock and reset
   input wire logic      clk,
   input wire logic      arst_n,
   // Bus pins
   input wire logic      scl_in,
   input wire logic      sda_in,
   input wire logic      sda_out,
   input wire logic      sda_oe,
   // Events and applied values
   input wire logic      reg_reset,
   input wire logic      watchdog_expire,
   input wire logic      plugin_detect_done,
   input wire setpoint_t setpoints,
   input wire logic      watchdog_expired_flag
);
   // ******
   // Setpoint checks
   // ******
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   property p_rst_cell;
      reg_reset |-> ##[1:4] setpoints.per_cell_charge_voltage == 8'hA0;
   endproperty
   a_rst_cell: assert property (p_rst_cell)
      else $error("cell voltage not back to default");
   property p_rst_chg;
      reg_reset |-> ##[1:4] setpoints.fast_charge_current == 6'h1E
         && !setpoints.high_impedance_enable && setpoints.limit_pin_enable;
   endproperty
   a_rst_chg: assert property (p_rst_chg)
      else $error("charge current register not back to default");
   property p_rst_vin;
      reg_reset |-> ##[1:4] setpoints.floor_reload_on_plugin && !setpoints.battery_load_enable
         && !setpoints.out_of_audio_disable && setpoints.input_voltage_floor == 5'h04;
   endproperty
   a_rst_vin: assert property (p_rst_vin)
      else $error("input voltage register not back to default");
   property p_wd_def;
      watchdog_expire |-> ##[1:4] setpoints.per_cell_charge_voltage == 8'hA0
         && setpoints.fast_charge_current == 6'h1E && setpoints.limit_pin_enable
         && !setpoints.battery_load_enable && setpoints.floor_reload_on_plugin;
   endproperty
   a_wd_def: assert property (p_wd_def)
      else $error("watchdog did not restore defaults");
   property p_wd_keep;
      watchdog_expire && !reg_reset && !plugin_detect_done |-> ##4 {setpoints.out_of_audio_disable,
         setpoints.input_voltage_floor} == $past({setpoints.out_of_audio_disable,
         setpoints.input_voltage_floor}, 4);
   endproperty
   a_wd_keep: assert property (p_wd_keep)
      else $error("watchdog changed a kept field");
   property p_wd_flag;
      watchdog_expire |-> ##[1:3] watchdog_expired_flag;
   endproperty
   a_wd_flag: assert property (p_wd_flag)
      else $error("default mode flag not set");
   property p_clamp_chg;
      $past(arst_n, 3) |-> setpoints.fast_charge_current inside {[6'h01:6'h2C]};
   endproperty
   a_clamp_chg: assert property (p_clamp_chg)
      else $error("charge current code outside clamp");
   property p_clamp_vin;
      $past(arst_n, 3) |-> setpoints.input_voltage_floor <= 5'h10;
   endproperty
   a_clamp_vin: assert property (p_clamp_vin)
      else $error("voltage floor code outside clamp");
   property p_plug_on;
      plugin_detect_done && setpoints.floor_reload_on_plugin && !reg_reset
         |-> ##[1:4] setpoints.input_voltage_floor == 5'h04;
   endproperty
   a_plug_on: assert property (p_plug_on)
      else $error("floor not reloaded on plug-in");
   property p_plug_off;
      plugin_detect_done && !setpoints.floor_reload_on_plugin && !reg_reset && !watchdog_expire
         |-> ##4 setpoints.input_voltage_floor == $past(setpoints.input_voltage_floor, 4);
   endproperty
   a_plug_off: assert property (p_plug_off)
      else $error("floor reloaded while reload disabled");
endmodule

// ==== tb/i2c_host_model.sv ====
`timescale 1ns/1ns
module i2c_host_model (
   // Clock
   input wire logic clk,
   // Bus lines
   input wire logic sda,
   output logic     scl,
   output logic     pull
);
   // ******
   // Bus host
   // ******
   initial begin
      scl = 1'b1;
      pull = 1'b0;
   end
   task automatic w(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Serves as repeated start too, so it begins by releasing the data line.
   task automatic start();
      w(1);
      pull = 1'b0;
      w(3);
      scl = 1'b1;
      w(4);
      pull = 1'b1;
      w(4);
      scl = 1'b0;
   endtask
   task automatic stop();
      w(1);
      pull = 1'b1;
      w(3);
      scl = 1'b1;
      w(4);
      pull = 1'b0;
      w(4);
   endtask
   // Data moves one clock after the fall so it never looks like a start or stop.
   task automatic xfer(input logic b, output logic r);
      w(1);
      pull = !b;
      w(3);
      scl = 1'b1;
      w(2);
      r = sda;
      w(2);
      scl = 1'b0;
   endtask
   task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q,
                          output logic r);
      for (int i = 7; i >= 0; i--) xfer(d[i], q[i]);
      xfer(a, r);
   endtask
endmodule

// ==== tb/charger_setpoint_registers_test.sv ====
`timescale 1ns/1ns
module charger_setpoint_registers_test
   import charger_pkg::*;
;
   logic       clk = 1'b0;
   logic       arst_n = 1'b0;
   logic       reg_reset = 1'b0;
   logic       watchdog_expire = 1'b0;
   logic       plugin_detect_done = 1'b0;
   logic       sda_out;
   logic       sda_oe;
   logic       scl;
   logic       pull;
   logic       wdf;
   wire        sda = !((sda_oe & !sda_out) | pull);
   setpoint_t  setpoints;
   int         fails = 0;
   int         comparisons = 0;
   int         cycles = 0;
   int         seed = 15170;
   logic [7:0] m [0:3];
   localparam logic [15:0] corner [7] = '{16'h01C0, 16'h013F, 16'h012C, 16'h012D,
                                          16'h027F, 16'h0211, 16'h0455};

   always #50 clk = ~clk;

   charger_setpoint_registers dut (.clk, .arst_n, .scl_in(scl), .sda_in(sda), .sda_out,
      .sda_oe, .reg_reset, .watchdog_expire, .plugin_detect_done, .setpoints,
      .watchdog_expired_flag(wdf));
   i2c_host_model host (.clk, .sda, .scl, .pull);

   // ******
   // Checking and bus tasks
   // ******
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   function automatic setpoint_t applied();
      logic [5:0] c;
      logic [4:0] f;
      c = m[1][5:0];
      f = m[2][4:0];
      if (c > 6'h2C) c = 6'h2C;
      if (c < 6'h01) c = 6'h01;
      if (f > 5'h10) f = 5'h10;
      return {m[0], m[1][7:6], c, m[2][7:5], f, m[3]};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic       r;
      host.start();
      host.byte_io(8'hD6, 1'b1, q, r);
      check(r, 1'b0);
      host.byte_io(a, 1'b1, q, r);
      check(r, a > 8'h03);
      if (!r) begin
         host.byte_io(d, 1'b1, q, r);
         check(r, 1'b0);
         m[a[1:0]] = d;
      end
      host.stop();
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      logic r;
      host.start();
      host.byte_io(8'hD6, 1'b1, q, r);
      host.byte_io(a, 1'b1, q, r);
      host.start();
      host.byte_io(8'hD7, 1'b1, q, r);
      check(r, 1'b0);
      host.byte_io(8'hFF, 1'b1, q, r);
      host.stop();
   endtask
   task automatic verify();
      logic [7:0] q;
      for (int i = 0; i < 4; i++) begin
         rd(8'(i), q);
         check(q, m[i]);
      end
      check(setpoints, applied());
   endtask
   // One-cycle pulse: 0 register reset, 1 watchdog, 2 plug-in detection.
   task automatic ev(input int k);
      @(negedge clk);
      {reg_reset, watchdog_expire, plugin_detect_done} = 3'b100 >> k;
      @(negedge clk);
      {reg_reset, watchdog_expire, plugin_detect_done} = 3'b000;
      repeat (8) @(negedge clk);
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         fails++;
         give_verdict();
      end
   end

   // ******
   // Scenarios
   // ******
   initial begin
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] q;
      logic       r;
      m = '{8'hA0, 8'h5E, 8'h84, 8'h39};
      repeat (16) @(negedge clk);
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      verify();
      check(wdf, 1'b1);
      host.start();
      host.byte_io(8'hAC, 1'b1, q, r);
      check(r, 1'b1);
      host.stop();
      // Clamp corners and an undefined register first, then random traffic.
      for (int i = 0; i < 19; i++) begin
         if (i < 7) {a, d} = corner[i];
         else begin
            a = {6'h00, 2'($random(seed))};
            d = 8'($random(seed));
         end
         wr(a, d);
         if (a < 8'h04) begin
            rd(a, q);
            check(q, m[a[1:0]]);
         end
         check(setpoints, applied());
      end
      // Burst read across two registers, then a burst write that runs past the last one.
      host.start();
      host.byte_io(8'hD6, 1'b1, q, r);
      host.byte_io(8'h02, 1'b1, q, r);
      host.start();
      host.byte_io(8'hD7, 1'b1, q, r);
      host.byte_io(8'hFF, 1'b0, q, r);
      check(q, m[2]);
      host.byte_io(8'hFF, 1'b1, q, r);
      check(q, m[3]);
      host.stop();
      host.start();
      host.byte_io(8'hD6, 1'b1, q, r);
      host.byte_io(8'h03, 1'b1, q, r);
      host.byte_io(8'h15, 1'b1, q, r);
      check(r, 1'b0);
      m[3] = 8'h15;
      host.byte_io(8'h2A, 1'b1, q, r);
      check(r, 1'b1);
      host.stop();
      check(wdf, 1'b0);
      wr(8'h02, 8'h6A);
      wr(8'h01, 8'hBF);
      ev(1);
      m[0] = 8'hA0;
      m[1] = 8'h5E;
      m[2] = (m[2] & 8'h3F) | 8'h80;
      m[3] = m[3] & 8'h3F;
      check(wdf, 1'b1);
      verify();
      ev(2);
      m[2] = (m[2] & 8'hE0) | 8'h04;
      check(setpoints, applied());
      wr(8'h02, 8'h0A);
      ev(2);
      check(setpoints, applied());
      ev(0);
      m = '{8'hA0, 8'h5E, 8'h84, 8'h39};
      verify();
      give_verdict();
   end
endmodule

bind charger_setpoint_registers charger_setpoint_registers_asserts chk (.clk, .arst_n,
   .scl_in, .sda_in, .sda_out, .sda_oe, .reg_reset, .watchdog_expire, .plugin_detect_done,
   .setpoints, .watchdog_expired_flag);
